// ===== design/vppc_pkg.sv
// Package: constants, port-state codes and carrier structs for the VBUS power path control
package vppc_pkg;

    // Clock and time base
    localparam int CLK_PERIOD_PS = 5000;
    localparam int MS_PS = 1000000000;
    localparam int MS_CYCLES = MS_PS / CLK_PERIOD_PS;

    // Field widths
    localparam int MS_W = 10;
    localparam int OFS_W = 4;
    localparam int PCT_W = 5;
    localparam int MV_W = 16;
    localparam int STATE_W = 4;

    // Window and voltage constants
    localparam logic [PCT_W-1:0] BASE_WINDOW_PCT = 5'h05;
    localparam logic [MV_W-1:0] SAFE5V_MV = 16'h1388;

    // Reset defaults, replaced by the nonvolatile image just after reset release
    localparam logic [MS_W-1:0] BLANK_DEFAULT_MS = 10'h12c;
    localparam logic [MS_W-1:0] DISCHARGE_DEFAULT_MS = 10'h0c8;
    localparam logic [OFS_W-1:0] OFS_DEFAULT = 4'h0;

    // Codes of the port state report coming from the Type-C state machine
    localparam logic [STATE_W-1:0] ST_UNATTACHED = 4'h0;
    localparam logic [STATE_W-1:0] ST_ATTACHED_SRC = 4'h1;
    localparam logic [STATE_W-1:0] ST_ATTACHED_SNK = 4'h2;
    localparam logic [STATE_W-1:0] ST_UNORIENTED_DBG_SRC = 4'h3;
    localparam logic [STATE_W-1:0] ST_ORIENTED_DBG_SRC = 4'h4;
    localparam logic [STATE_W-1:0] ST_ERROR_RECOVERY = 4'h5;

    // Comparator results from the analog front end
    typedef struct packed {
        logic bus_above_high;
        logic bus_below_low;
        logic bus_above_uvlo;
        logic bus_vsafe0;
        logic vdd_above_uvlo;
        logic vdd_below_ovlo;
    } vppc_sense_t;

    // Configuration image, both nonvolatile and live
    typedef struct packed {
        logic supply_undervoltage_check_enable;
        logic supply_overvoltage_check_enable;
        logic bus_window_check_select;
        logic discharge_enable;
        logic [OFS_W-1:0] high_ofs;
        logic [OFS_W-1:0] low_ofs;
        logic [MS_W-1:0] discharge_ms;
        logic [MS_W-1:0] profile_change_blank_time;
    } vppc_cfg_t;

    // Software write strobes with their data
    typedef struct packed {
        logic checks_we;
        logic supply_undervoltage_check_enable;
        logic supply_overvoltage_check_enable;
        logic bus_window_check_select;
        logic high_we;
        logic [OFS_W-1:0] high_ofs;
        logic low_we;
        logic [OFS_W-1:0] low_ofs;
        logic discharge_we;
        logic [MS_W-1:0] discharge_ms;
    } vppc_sw_wr_t;

    // Phase of the control logic
    typedef enum logic [1:0] {
        VPPC_BOOT,
        VPPC_RUN
    } vppc_phase_t;

endpackage

// ===== design/vppc_ms_timer.sv
// Millisecond down-counter that reports busy while a loaded interval runs
`timescale 1ns/1ps
`default_nettype none
module vppc_ms_timer
    import vppc_pkg::*;
#(
    parameter int W = MS_W
) (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_ce,
    input wire logic i_ms_tick,
    input wire logic i_start,
    input wire logic [W-1:0] i_ms,
    output logic o_busy
);
    logic [W:0] count;
    logic [W:0] next_count;

    // One extra tick is loaded so the interval never falls short of i_ms
    always_comb begin
        next_count = count;
        if (i_start) begin
            next_count = {1'b0, i_ms} + {{W{1'b0}}, 1'b1};
        end else if (i_ms_tick && (count != '0)) begin
            next_count = count - {{W{1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            count <= '0;
        end else if (i_ce) begin
            count <= next_count;
        end
    end

    assign o_busy = (count != '0);
endmodule
`default_nettype wire

// ===== design/vppc_power_path.sv
// VBUS power path control: supervision, switch enables, blanking and discharge timing
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Bus must be valid before enabling sink switch; source may enable during blanking
// - Bad bus at attach blocks connection, switches
// - Later fault drops path; recovery or unattach
// - Nominal 5V at attach, profile value later; blank
// - Falling profile discharges bus during blanking
// - Window is nominal +/-5%, widened 0..15%
// - Offsets load from NVM; software writes while attached
// - Discharge at detach and error recovery entry
// - Discharge NVM-enabled; duration NVM or software
// - Supply checks in source role, each selectable
// - After source enable, supervise bus not supply
// - Window check default; UVLO-only test selectable
// - Source enable held while attached and valid
// - Source attach only from zero-volt bus
// - Sink enable when attached and bus valid
// - Each enable pin level shown as status
module vppc_power_path
    import vppc_pkg::*;
#(
    parameter int P_MS_CYCLES = MS_CYCLES
) (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_ce,
    input wire logic [STATE_W-1:0] i_port_state_report,
    input wire vppc_sense_t i_sense,
    input wire vppc_cfg_t i_nvm_cfg,
    input wire vppc_sw_wr_t i_sw_wr,
    input wire logic i_profile_change,
    input wire logic [MV_W-1:0] i_profile_mv,
    output logic o_source_power_switch_enable_o,
    output logic o_source_power_switch_enable_oe,
    output logic o_sink_power_switch_enable_o,
    output logic o_sink_power_switch_enable_oe,
    output logic o_source_switch_status,
    output logic o_sink_switch_status,
    output logic o_source_attach_allowed,
    output logic o_sink_attach_allowed,
    output logic o_error_recovery_request,
    output logic o_unattach_request,
    output logic o_discharge_active,
    output logic o_monitor_blanked,
    output logic [MV_W-1:0] o_nominal_mv,
    output logic [PCT_W-1:0] o_high_threshold_pct,
    output logic [PCT_W-1:0] o_low_threshold_pct,
    output vppc_cfg_t o_cfg
);
    localparam int TICK_W = $clog2(P_MS_CYCLES);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(P_MS_CYCLES - 1);

    vppc_phase_t phase;
    vppc_phase_t next_phase;
    vppc_cfg_t cfg;
    vppc_cfg_t next_cfg;
    logic [TICK_W-1:0] tick_cnt;
    logic [TICK_W-1:0] next_tick_cnt;
    logic ms_tick;
    logic [STATE_W-1:0] prev_state;
    logic [MV_W-1:0] nominal_mv;
    logic [MV_W-1:0] next_nominal_mv;
    logic src_on;
    logic next_src_on;
    logic snk_on;
    logic next_snk_on;
    logic err_req;
    logic next_err_req;
    logic unatt_req;
    logic next_unatt_req;
    logic src_status;
    logic snk_status;
    logic fall_discharge;
    logic next_fall_discharge;

    logic src_state;
    logic snk_state;
    logic attached;
    logic was_attached;
    logic attach_entry;
    logic detach_event;
    logic err_entry;
    logic bus_ok;
    logic vdd_ok;
    logic blanking;
    logic det_discharging;
    logic blank_start;
    logic det_start;
    logic bus_fault;

    // Role decode of the reported port state
    // Both debug accessory source states act as source attached
    assign src_state = (i_port_state_report == ST_ATTACHED_SRC) ||
                       (i_port_state_report == ST_UNORIENTED_DBG_SRC) ||
                       (i_port_state_report == ST_ORIENTED_DBG_SRC);
    assign snk_state = (i_port_state_report == ST_ATTACHED_SNK);
    assign attached = src_state || snk_state;
    assign was_attached = (prev_state == ST_ATTACHED_SRC) ||
                          (prev_state == ST_UNORIENTED_DBG_SRC) ||
                          (prev_state == ST_ORIENTED_DBG_SRC) ||
                          (prev_state == ST_ATTACHED_SNK);
    assign attach_entry = attached && !was_attached;
    assign detach_event = !attached && was_attached;
    assign err_entry = (i_port_state_report == ST_ERROR_RECOVERY) &&
                       (prev_state != ST_ERROR_RECOVERY);

    // Bus condition: window by default, single undervoltage test when selected
    assign bus_ok = cfg.bus_window_check_select ?
                    (!i_sense.bus_above_high && !i_sense.bus_below_low) :
                    i_sense.bus_above_uvlo;

    // Supply checks, each only when enabled
    assign vdd_ok = (!cfg.supply_undervoltage_check_enable || i_sense.vdd_above_uvlo) &&
                    (!cfg.supply_overvoltage_check_enable || i_sense.vdd_below_ovlo);

    // A fault only counts once monitoring is no longer blanked.
    // The attach edge is left out: the blank timer only runs from the next cycle,
    // and a source always sees a dead bus at attach, so without this the port
    // would be pushed into error recovery on every attach.
    assign bus_fault = attached && !attach_entry && !blanking && !bus_ok;

    // Timer starts: attach or profile change blanks; detach or recovery discharges
    assign blank_start = i_ce && (phase == VPPC_RUN) &&
                         (attach_entry || (attached && i_profile_change));
    assign det_start = i_ce && (phase == VPPC_RUN) && cfg.discharge_enable &&
                       (detach_event || err_entry);

    // Millisecond prescaler shared by both timers
    // Free-running, so an interval of N ms lasts between N and N+1 ms
    always_comb begin
        next_tick_cnt = tick_cnt + {{(TICK_W-1){1'b0}}, 1'b1};
        if (tick_cnt == TICK_LAST) begin
            next_tick_cnt = '0;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            tick_cnt <= '0;
        end else if (i_ce) begin
            tick_cnt <= next_tick_cnt;
        end
    end

    assign ms_tick = (tick_cnt == TICK_LAST);

    // Monitoring blank interval after attach and after each profile change
    // One length for both cases; only the nonvolatile image sets it
    vppc_ms_timer #(
        .W(MS_W)
    ) u_blank_timer (
        .i_core_clk(i_core_clk),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .i_ms_tick(ms_tick),
        .i_start(blank_start),
        .i_ms(cfg.profile_change_blank_time),
        .o_busy(blanking)
    );

    // Discharge interval after detach or error recovery entry
    // A new start while busy reloads the full interval
    vppc_ms_timer #(
        .W(MS_W)
    ) u_discharge_timer (
        .i_core_clk(i_core_clk),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .i_ms_tick(ms_tick),
        .i_start(det_start),
        .i_ms(cfg.discharge_ms),
        .o_busy(det_discharging)
    );

    // Configuration: NVM image captured once after reset, then software updates
    always_comb begin
        next_phase = phase;
        next_cfg = cfg;
        case (phase)
            VPPC_BOOT: begin
                next_cfg = i_nvm_cfg;
                next_phase = VPPC_RUN;
            end
            VPPC_RUN: begin
                if (i_sw_wr.checks_we) begin
                    next_cfg.supply_undervoltage_check_enable =
                        i_sw_wr.supply_undervoltage_check_enable;
                    next_cfg.supply_overvoltage_check_enable =
                        i_sw_wr.supply_overvoltage_check_enable;
                    next_cfg.bus_window_check_select = i_sw_wr.bus_window_check_select;
                end
                // Offsets are only writable while a partner is attached
                if (i_sw_wr.high_we && attached) begin
                    next_cfg.high_ofs = i_sw_wr.high_ofs;
                end
                if (i_sw_wr.low_we && attached) begin
                    next_cfg.low_ofs = i_sw_wr.low_ofs;
                end
                // Discharge enable has no software path on purpose
                if (i_sw_wr.discharge_we) begin
                    next_cfg.discharge_ms = i_sw_wr.discharge_ms;
                end
            end
            default: begin
                next_phase = VPPC_BOOT;
            end
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            phase <= VPPC_BOOT;
            cfg <= '{supply_undervoltage_check_enable: 1'b0,
                     supply_overvoltage_check_enable: 1'b0,
                     bus_window_check_select: 1'b1,
                     discharge_enable: 1'b1,
                     high_ofs: OFS_DEFAULT,
                     low_ofs: OFS_DEFAULT,
                     discharge_ms: DISCHARGE_DEFAULT_MS,
                     profile_change_blank_time: BLANK_DEFAULT_MS};
        end else if (i_ce) begin
            phase <= next_phase;
            cfg <= next_cfg;
        end
    end

    // Nominal level, switch enables, fault requests and profile discharge
    always_comb begin
        next_nominal_mv = nominal_mv;
        next_fall_discharge = fall_discharge && blanking;
        if (attach_entry) begin
            next_nominal_mv = SAFE5V_MV;
            next_fall_discharge = 1'b0;
        end else if (attached && i_profile_change) begin
            next_nominal_mv = i_profile_mv;
            next_fall_discharge = (i_profile_mv < nominal_mv);
        end
        // Supply gates only the first assertion; after that the bus alone rules
        next_src_on = src_state && (src_on || vdd_ok) &&
                      (bus_ok || blanking) && (phase == VPPC_RUN);
        // Sink needs a good bus to turn on; blanking only protects an enabled path
        next_snk_on = snk_state && (bus_ok || (blanking && snk_on)) &&
                      (phase == VPPC_RUN);
        next_err_req = src_state && bus_fault;
        next_unatt_req = snk_state && bus_fault;
        if (!attached) begin
            next_fall_discharge = 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            prev_state <= ST_UNATTACHED;
            nominal_mv <= SAFE5V_MV;
            src_on <= 1'b0;
            snk_on <= 1'b0;
            err_req <= 1'b0;
            unatt_req <= 1'b0;
            fall_discharge <= 1'b0;
            src_status <= 1'b1;
            snk_status <= 1'b1;
        end else if (i_ce) begin
            prev_state <= i_port_state_report;
            nominal_mv <= next_nominal_mv;
            src_on <= next_src_on;
            snk_on <= next_snk_on;
            err_req <= next_err_req;
            unatt_req <= next_unatt_req;
            fall_discharge <= next_fall_discharge;
            // Status mirrors the pin level as seen with its pull-up
            src_status <= !next_src_on;
            snk_status <= !next_snk_on;
        end
    end

    // Open-drain enables only ever pull low; released means high impedance
    // The off-chip pull-up then holds the PMOS gate high, so the switch stays off
    assign o_source_power_switch_enable_o = 1'b0;
    assign o_source_power_switch_enable_oe = src_on;
    assign o_sink_power_switch_enable_o = 1'b0;
    assign o_sink_power_switch_enable_oe = snk_on;
    assign o_source_switch_status = src_status;
    assign o_sink_switch_status = snk_status;

    // Attach gating towards the port state machine
    // Source needs a dead bus and good supply; sink needs the selected bus test
    assign o_source_attach_allowed = i_sense.bus_vsafe0 && vdd_ok;
    assign o_sink_attach_allowed = bus_ok;

    // Plain state outputs; thresholds leave as percentages for the analog comparators
    assign o_error_recovery_request = err_req;
    assign o_unattach_request = unatt_req;
    assign o_discharge_active = det_discharging || (fall_discharge && blanking);
    assign o_monitor_blanked = blanking;
    assign o_nominal_mv = nominal_mv;
    assign o_high_threshold_pct = BASE_WINDOW_PCT + {1'b0, cfg.high_ofs};
    assign o_low_threshold_pct = BASE_WINDOW_PCT + {1'b0, cfg.low_ofs};
    assign o_cfg = cfg;
endmodule
`default_nettype wire

// ===== test/vppc_power_path_asserts.sv
// Checker of the power path control ports
`timescale 1ns/1ps
`default_nettype none
module vppc_power_path_asserts
    import vppc_pkg::*;
#(
    parameter int P_MS_CYCLES = MS_CYCLES
) (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic [STATE_W-1:0] i_port_state_report,
    input wire vppc_sense_t i_sense,
    input wire logic i_profile_change,
    input wire logic o_source_power_switch_enable_oe,
    input wire logic o_sink_power_switch_enable_oe,
    input wire logic o_source_switch_status,
    input wire logic o_sink_switch_status,
    input wire logic o_source_attach_allowed,
    input wire logic o_error_recovery_request,
    input wire logic o_unattach_request,
    input wire logic o_discharge_active,
    input wire logic o_monitor_blanked,
    input wire logic [PCT_W-1:0] o_high_threshold_pct,
    input wire logic [PCT_W-1:0] o_low_threshold_pct,
    input wire vppc_cfg_t o_cfg
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);
    logic bus_ok;
    logic sup_ok;
    logic src_st;
    logic snk_st;
    // Bus and supply conditions as the selected supervision modes see them
    assign bus_ok = o_cfg.bus_window_check_select ?
        !(i_sense.bus_above_high || i_sense.bus_below_low) : i_sense.bus_above_uvlo;
    assign sup_ok = (!o_cfg.supply_undervoltage_check_enable || i_sense.vdd_above_uvlo)
        && (!o_cfg.supply_overvoltage_check_enable || i_sense.vdd_below_ovlo);
    assign src_st = i_port_state_report inside {ST_ATTACHED_SRC, ST_UNORIENTED_DBG_SRC,
        ST_ORIENTED_DBG_SRC};
    assign snk_st = i_port_state_report == ST_ATTACHED_SNK;

    a_src_oe_state: assert property (o_source_power_switch_enable_oe |-> $past(src_st))
        else $error("source enable outside a source state");
    a_snk_oe_state: assert property (o_sink_power_switch_enable_oe |-> $past(snk_st))
        else $error("sink enable outside the sink state");
    a_status_pin: assert property ((o_source_switch_status == !o_source_power_switch_enable_oe)
        && (o_sink_switch_status == !o_sink_power_switch_enable_oe))
        else $error("status bit differs from pin level");
    a_src_vsafe0: assert property (o_source_attach_allowed |-> i_sense.bus_vsafe0 && sup_ok)
        else $error("source attach allowed without safe bus");
    a_thresh_pct: assert property (o_high_threshold_pct == BASE_WINDOW_PCT + {1'b0, o_cfg.high_ofs}
        && o_low_threshold_pct == BASE_WINDOW_PCT + {1'b0, o_cfg.low_ofs})
        else $error("threshold percentage wrong");
    a_src_supply: assert property ($rose(o_source_power_switch_enable_oe) |-> $past(sup_ok))
        else $error("source enabled with supply fault");
    a_snk_bus_ok: assert property ($rose(o_sink_power_switch_enable_oe) |-> $past(bus_ok))
        else $error("sink enabled with bus invalid");
    a_src_fault: assert property (src_st && o_source_power_switch_enable_oe && !bus_ok
        && !o_monitor_blanked |=> !o_source_power_switch_enable_oe && o_error_recovery_request)
        else $error("source fault not handled");
    a_snk_fault: assert property (snk_st && o_sink_power_switch_enable_oe && !bus_ok
        && !o_monitor_blanked |=> !o_sink_power_switch_enable_oe && o_unattach_request)
        else $error("sink fault not handled");
    a_blank_profile: assert property (i_profile_change && src_st |=> o_monitor_blanked)
        else $error("no blanking after profile change");
    a_detach_disch: assert property (o_cfg.discharge_enable
        && ((i_port_state_report == ST_UNATTACHED && $past(src_st || snk_st))
        || (i_port_state_report == ST_ERROR_RECOVERY
        && $past(i_port_state_report) != ST_ERROR_RECOVERY)) |=> o_discharge_active)
        else $error("no discharge at detach or recovery");
    a_attach_quiet: assert property ((src_st || snk_st) && !$past(src_st || snk_st)
        |=> !o_error_recovery_request && !o_unattach_request)
        else $error("fault request raised at attach");

    c_src_on: cover property ($rose(o_source_power_switch_enable_oe));
    c_snk_on: cover property ($rose(o_sink_power_switch_enable_oe));
    c_disch: cover property ($rose(o_discharge_active));
endmodule
`default_nettype wire

// ===== test/vppc_pmos_model.sv
// Model of the external PMOS switches on the two open-drain enable pins
`timescale 1ns/1ps
`default_nettype none
module vppc_pmos_model (
    input wire logic i_src_o,
    input wire logic i_src_oe,
    input wire logic i_snk_o,
    input wire logic i_snk_oe,
    output logic o_src_on,
    output logic o_snk_on
);
    // Pull-up keeps a released gate high, so the PMOS conducts only on a driven low
    assign o_src_on = !(i_src_oe ? i_src_o : 1'b1);
    assign o_snk_on = !(i_snk_oe ? i_snk_o : 1'b1);
endmodule
`default_nettype wire

// ===== test/vppc_power_path_bench.sv
// Testbench of the power path control with the switch model
`timescale 1ns/1ps
`default_nettype none
module vppc_power_path_bench;
    import vppc_pkg::*;
    localparam int P = 10;
    logic clk, resetn, pchg, src_o, src_oe, snk_o, snk_oe, src_on, snk_on, allow, err, unatt;
    logic disch, blank, sallow, ce;
    logic [STATE_W-1:0] state;
    logic [MV_W-1:0] pmv, nom;
    logic [PCT_W-1:0] hi, lo;
    vppc_sense_t sense;
    vppc_cfg_t nvm, cfg;
    vppc_sw_wr_t sw;
    int miscompares = 0;
    int cmp_count = 0;
    int cycles = 0;

    vppc_power_path #(.P_MS_CYCLES(P)) dut_u (.i_core_clk(clk), .i_resetn(resetn),
        .i_ce(ce), .i_port_state_report(state), .i_sense(sense), .i_nvm_cfg(nvm),
        .i_sw_wr(sw), .i_profile_change(pchg), .i_profile_mv(pmv),
        .o_source_power_switch_enable_o(src_o), .o_source_power_switch_enable_oe(src_oe),
        .o_sink_power_switch_enable_o(snk_o), .o_sink_power_switch_enable_oe(snk_oe),
        .o_source_switch_status(), .o_sink_switch_status(), .o_source_attach_allowed(allow),
        .o_sink_attach_allowed(sallow), .o_error_recovery_request(err), .o_unattach_request(unatt),
        .o_discharge_active(disch), .o_monitor_blanked(blank), .o_nominal_mv(nom),
        .o_high_threshold_pct(hi), .o_low_threshold_pct(lo), .o_cfg(cfg));
    vppc_pmos_model pmos_u (.i_src_o(src_o), .i_src_oe(src_oe), .i_snk_o(snk_o),
        .i_snk_oe(snk_oe), .o_src_on(src_on), .o_snk_on(snk_on));

    // Clock and a ceiling well above the few hundred cycles the run needs
    always #2.5 clk = !clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            finish_test();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk1(input string name, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic chkv(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Bus comparators: above high, below low, above uvlo, at zero volts
    task automatic bus(input logic [3:0] b);
        sense[5:2] = b;
    endtask
    // Counts the remaining cycles of discharge; bounded so a stuck timer cannot hang
    task automatic span(input int ms, input string name);
        int n;
        n = 0;
        while (disch === 1'b1 && n < 100) begin
            cyc(1);
            n++;
        end
        chk1(name, 1'b1, n >= ms * P - 2 && n <= (ms + 1) * P + 1);
    endtask

    task automatic t_boot();
        chkv("cfg", nvm, cfg);
        chkv("high pct", 32'h7, hi);
        chkv("low pct", 32'h9, lo);
    endtask
    task automatic t_src();
        state = ST_ATTACHED_SRC;
        chk1("attach allowed", 1'b1, allow);
        cyc(2);
        chk1("src on", 1'b1, src_on);
        chkv("nominal", 32'h1388, nom);
        chk1("blanked", 1'b1, blank);
        bus(4'h2);
        sense[1:0] = 2'h0; // Supply no longer watched once the switch is on
        cyc(45);
        chk1("blank end", 1'b0, blank);
        chk1("src held", 1'b1, src_on);
        sw.high_we = 1'b1;
        sw.high_ofs = 4'hf;
        cyc(1);
        sw.high_we = 1'b0;
        chkv("high pct max", 32'h14, hi);
        pchg = 1'b1;
        pmv = 16'h0bb8;
        cyc(1);
        pchg = 1'b0;
        chkv("profile nominal", 32'h0bb8, nom);
        chk1("profile blank", 1'b1, blank);
        span(3, "profile discharge");
        chk1("blank with discharge", 1'b0, blank);
        bus(4'ha);
        cyc(2);
        chk1("fault recovery", 1'b1, err);
        chk1("fault src off", 1'b0, src_on);
        state = ST_ERROR_RECOVERY;
        cyc(2);
        chk1("recovery discharge", 1'b1, disch);
        state = ST_UNATTACHED;
        bus(4'h5);
        cyc(25);
    endtask
    task automatic t_supply();
        sense[1:0] = 2'h1;
        state = ST_ORIENTED_DBG_SRC;
        cyc(3);
        chk1("allow low vdd", 1'b0, allow);
        chk1("src blocked", 1'b0, src_on);
        state = ST_UNATTACHED;
        sense[1:0] = 2'h3;
        cyc(25);
    endtask
    task automatic t_snk();
        ce = 1'b0; // Writes held while the clock enable is low
        sw.low_we = 1'b1;
        sw.low_ofs = 4'h1;
        sw.checks_we = 1'b1;
        sw.supply_undervoltage_check_enable = 1'b1;
        sw.supply_overvoltage_check_enable = 1'b1;
        sw.discharge_we = 1'b1;
        sw.discharge_ms = 10'h001;
        cyc(1);
        chk1("frozen select", 1'b1, cfg.bus_window_check_select);
        ce = 1'b1;
        cyc(1);
        sw = '0;
        chkv("low pct kept", 32'h9, lo);
        chk1("uvlo test", 1'b0, cfg.bus_window_check_select);
        state = ST_ATTACHED_SNK;
        bus(4'h4);
        cyc(3);
        chk1("snk allow low", 1'b0, sallow);
        chk1("snk blocked", 1'b0, snk_on);
        bus(4'ha);
        cyc(2);
        chk1("snk allow", 1'b1, sallow);
        chk1("snk on", 1'b1, snk_on);
        // Attach blanking must run out before a bus fault can count
        cyc(40);
        chk1("snk blank end", 1'b0, blank);
        bus(4'h4);
        cyc(2);
        chk1("snk off", 1'b0, snk_on);
        chk1("unattach", 1'b1, unatt);
        state = ST_UNATTACHED;
        cyc(2);
        span(1, "detach discharge");
    endtask

    task automatic finish_test();
        $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Boot image: both supply checks, window test, discharge on, offsets 2/4, 2 ms, 3 ms
    initial begin
        clk = 1'b0;
        ce = 1'b1;
        resetn = 1'b0;
        state = ST_UNATTACHED;
        pchg = 1'b0;
        pmv = 16'h0000;
        sw = '0;
        sense = 6'h17;
        nvm = {4'hf, 4'h2, 4'h4, 10'h002, 10'h003};
        repeat (10) @(posedge clk);
        #1;
        resetn = 1'b1;
        cyc(3);
        t_boot();
        t_src();
        t_supply();
        t_snk();
        finish_test();
    end
endmodule

bind vppc_power_path vppc_power_path_asserts #(.P_MS_CYCLES(P_MS_CYCLES)) chk_u (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_port_state_report(i_port_state_report),
    .i_sense(i_sense), .i_profile_change(i_profile_change),
    .o_source_power_switch_enable_oe(o_source_power_switch_enable_oe),
    .o_sink_power_switch_enable_oe(o_sink_power_switch_enable_oe),
    .o_source_switch_status(o_source_switch_status), .o_sink_switch_status(o_sink_switch_status),
    .o_source_attach_allowed(o_source_attach_allowed),
    .o_error_recovery_request(o_error_recovery_request), .o_unattach_request(o_unattach_request),
    .o_discharge_active(o_discharge_active), .o_monitor_blanked(o_monitor_blanked),
    .o_high_threshold_pct(o_high_threshold_pct), .o_low_threshold_pct(o_low_threshold_pct),
    .o_cfg(o_cfg));
`default_nettype wire
